// *** zfm_ctrl.sv ***
// zero flag routing and multilevel noise-shaping modulator
// assumes samples and select bits synchronous to core_clk
// How it works
// RQ1: polarity bit inverts flag pin level
// RQ2: reset clears both select bits
// RQ3: unmerged: pin one right, pin two left
// RQ4: merged: pin one common, pin two idle
// RQ5: eight-level quantizer, fourth-order noise shaping
// RQ6: default oversampling is sixty-four times
// RQ7: double bit with fast clock gives 128
// RQ8: flag after zero run, clear nonzero
`timescale 1ns/1ps
`default_nettype none
module zfm_ctrl
  import zfm_pkg::*;
#(
  parameter int RUN_LEN = ZERO_RUN_SAMPLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // select bits from the control port
  input wire logic flag_polarity_select,
  input wire logic flag_merge_select,
  input wire logic select_load,
  input wire logic oversample_double,
  input wire logic [10:0] sck_ratio,
  // audio samples, one-cycle strobes
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] left_sample,
  input wire logic [SAMPLE_W-1:0] right_sample,
  // oversampled data feed, one strobe per modulator step
  input wire logic mod_step,
  input wire logic signed [SAMPLE_W-1:0] mod_in,
  // flag pins
  output logic flag_pin1,
  output logic flag_pin2,
  output logic flag_pin2_oe,
  // modulator output
  output logic [2:0] mod_code,
  output logic [7:0] osr_factor
);

  // ------------------------------------------------------------
  // select bits
  // ------------------------------------------------------------
  logic polarity;
  logic merge;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      polarity <= RST_POLARITY; // [RQ2]
      merge <= RST_MERGE; // [RQ2]
    end else if (select_load) begin
      polarity <= flag_polarity_select;
      merge <= flag_merge_select;
    end
  end

  // ------------------------------------------------------------
  // silence detection
  // ------------------------------------------------------------
  localparam int CNT_W = $clog2(RUN_LEN + 1);
  localparam logic [CNT_W-1:0] RUN_TOP = CNT_W'(RUN_LEN);
  logic [CNT_W-1:0] left_run;
  logic [CNT_W-1:0] right_run;
  logic left_silence_flag;
  logic right_silence_flag;

  function automatic logic [CNT_W-1:0] run_next(
    input logic [CNT_W-1:0] run, input logic is_zero);
    if (!is_zero) begin
      run_next = '0;
    end else if (run == RUN_TOP) begin
      run_next = run;
    end else begin
      run_next = run + CNT_W'(1);
    end
  endfunction : run_next

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      left_run <= '0;
      right_run <= '0;
    end else if (sample_valid) begin
      left_run <= run_next(left_run, left_sample == '0); // [RQ8]
      right_run <= run_next(right_run, right_sample == '0); // [RQ8]
    end
  end
  assign left_silence_flag = (left_run == RUN_TOP);
  assign right_silence_flag = (right_run == RUN_TOP);

  // ------------------------------------------------------------
  // flag pins
  // ------------------------------------------------------------
  logic common_silence_flag;
  assign common_silence_flag = left_silence_flag & right_silence_flag;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_pin1 <= 1'b0;
      flag_pin2 <= 1'b0;
      flag_pin2_oe <= 1'b1;
    end else if (merge) begin
      flag_pin1 <= common_silence_flag ^ polarity; // [RQ4] [RQ1]
      flag_pin2 <= 1'b0; // [RQ4]
      flag_pin2_oe <= 1'b0;
    end else begin
      flag_pin1 <= right_silence_flag ^ polarity; // [RQ3] [RQ1]
      flag_pin2 <= left_silence_flag ^ polarity; // [RQ3] [RQ1]
      flag_pin2_oe <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // oversampling rate
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osr_factor <= 8'(OSR_BASE);
    end else if (oversample_double && sck_ratio >= 11'(SCK_RATIO_MIN)) begin
      osr_factor <= 8'(OSR_DOUBLE); // [RQ7]
    end else begin
      osr_factor <= 8'(OSR_BASE); // [RQ6]
    end
  end

  // ------------------------------------------------------------
  // modulator: chain of four integrators, 8-level quantizer
  // ------------------------------------------------------------
  // simple cascade of integrators with feedback; stability for
  // near full-scale input depends on upstream headroom
  logic signed [ACC_W-1:0] integ [MOD_ORDER];
  logic signed [ACC_W-1:0] fb;
  logic [2:0] next_code;

  function automatic logic [2:0] quantize(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] lvl;
    lvl = (v >>> (SAMPLE_W - 3)) + ACC_W'(signed'(4));
    if (lvl < 0) begin
      quantize = 3'h0;
    // widen first: a 3-bit seven taken as signed would be minus one
    end else if (lvl > $signed(ACC_W'(CODE_MAX))) begin
      quantize = CODE_MAX;
    end else begin
      quantize = lvl[2:0];
    end
  endfunction : quantize

  assign next_code = quantize(integ[MOD_ORDER-1]); // [RQ5]
  assign fb = (ACC_W'(signed'({1'b0, mod_code})) - ACC_W'(signed'(4)))
              <<< (SAMPLE_W - 3);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MOD_ORDER; i++) begin
        integ[i] <= '0;
      end
      mod_code <= CODE_MID;
    end else if (mod_step) begin
      integ[0] <= integ[0] + ACC_W'(mod_in) - fb; // [RQ5]
      for (int i = 1; i < MOD_ORDER; i++) begin
        integ[i] <= integ[i] + integ[i-1] - fb; // [RQ5]
      end
      mod_code <= next_code;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  pin2_idle_a: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (rst)
    merge |=> !flag_pin2_oe && !flag_pin2)
    else $error("pin two driven while merged");
  pin1_common_a: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (rst)
    merge |=> flag_pin1 == ($past(common_silence_flag) ^ $past(polarity)))
    else $error("pin one not common flag");
  pin2_driven_a: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (rst)
    !merge |=> flag_pin2_oe)
    else $error("pin two released while independent");
  pin1_right_a: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (rst)
    !merge |=> flag_pin1 == ($past(right_silence_flag) ^ $past(polarity)))
    else $error("pin one not right flag");
  pin2_left_a: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (rst)
    !merge |=> flag_pin2 == ($past(left_silence_flag) ^ $past(polarity)))
    else $error("pin two not left flag");
  polarity_idle_a: assert property ( // [RQ1]
    @(posedge core_clk) disable iff (rst)
    (!left_silence_flag && !right_silence_flag && !merge) |=>
    flag_pin1 == $past(polarity))
    else $error("idle pin level wrong for polarity");
  flag_rise_a: assert property ( // [RQ8]
    @(posedge core_clk) disable iff (rst)
    (sample_valid && left_sample == '0 && left_run == RUN_TOP - CNT_W'(1))
    |=> left_silence_flag)
    else $error("left flag late after zero run");
  flag_clear_a: assert property ( // [RQ8]
    @(posedge core_clk) disable iff (rst)
    (sample_valid && left_sample != '0) |=> !left_silence_flag)
    else $error("left flag kept after nonzero sample");
  right_clear_a: assert property ( // [RQ8]
    @(posedge core_clk) disable iff (rst)
    (sample_valid && right_sample != '0) |=> !right_silence_flag)
    else $error("right flag kept after nonzero sample");
  osr_double_a: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (rst)
    (oversample_double && sck_ratio >= 11'(SCK_RATIO_MIN)) |=>
    osr_factor == 8'(OSR_DOUBLE))
    else $error("oversampling not doubled");
  osr_base_a: assert property ( // [RQ6]
    @(posedge core_clk) disable iff (rst)
    !oversample_double |=> osr_factor == 8'(OSR_BASE))
    else $error("oversampling not 64");
  osr_slow_a: assert property ( // [RQ6]
    @(posedge core_clk) disable iff (rst)
    (sck_ratio < 11'(SCK_RATIO_MIN)) |=> osr_factor == 8'(OSR_BASE))
    else $error("oversampling raised on slow clock");
  code_hold_a: assert property ( // [RQ5]
    @(posedge core_clk) disable iff (rst)
    !mod_step |=> $stable(mod_code))
    else $error("code moved without step");
  code_step_a: assert property ( // [RQ5]
    @(posedge core_clk) disable iff (rst)
    mod_step |=> mod_code == $past(next_code))
    else $error("code not taken from quantizer");
  select_keep_a: assert property ( // [RQ2]
    @(posedge core_clk) disable iff (rst)
    !select_load |=> $stable(polarity) && $stable(merge))
    else $error("select bits changed without load");

endmodule : zfm_ctrl
`default_nettype wire

// *** zfm_ctrl_tb.sv ***
// self-checking bench for zfm_ctrl with a short silence run
// assumes zfm_pkg, zfm_ctrl and zfm_flag_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module zfm_ctrl_tb;
  import zfm_pkg::*;
  localparam int RL = 4;
  logic core_clk = 0, rst = 1, pol = 0, mrg = 0, ld = 0, dbl = 0, sv = 0;
  logic ms = 0, p1, p2, oe, rsil, lsil, lf, rf;
  logic [10:0] ratio = 11'h100;
  logic [SAMPLE_W-1:0] ls = '0, rs = '0, mi = '0;
  logic [2:0] code, hi = 3'h0, lo = 3'h7;
  logic [7:0] osr;
  int num_errors = 0, cmp_count = 0, lrun = 0, rrun = 0, cyc = 0;
  zfm_ctrl #(.RUN_LEN(RL)) i_dut (.core_clk(core_clk), .rst(rst),
    .flag_polarity_select(pol), .flag_merge_select(mrg), .select_load(ld),
    .oversample_double(dbl), .sck_ratio(ratio), .sample_valid(sv),
    .left_sample(ls), .right_sample(rs), .mod_step(ms), .mod_in(mi),
    .flag_pin1(p1), .flag_pin2(p2), .flag_pin2_oe(oe), .mod_code(code),
    .osr_factor(osr));
  zfm_flag_monitor i_mon (.flag_pin1(p1), .flag_pin2(p2),
    .flag_pin2_oe(oe), .pol(pol), .right_silent(rsil), .left_silent(lsil));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [2:0] pins_exp(logic zl, logic zr, logic m,
    logic p);
    return m ? {(zl & zr) ^ p, 2'b00} : {zr ^ p, zl ^ p, 1'b1};
  endfunction : pins_exp
  function automatic logic [7:0] osr_exp(logic d, logic [10:0] r);
    return (d && r >= 11'(SCK_RATIO_MIN)) ? 8'(OSR_DOUBLE) : 8'(OSR_BASE);
  endfunction : osr_exp
  task automatic step(logic [SAMPLE_W-1:0] l, logic [SAMPLE_W-1:0] r);
    logic [2:0] want;
    ls = l;
    rs = r;
    sv = 1;
    @(negedge core_clk) sv = 0;
    lrun = (l == 0) ? lrun + 1 : 0;
    rrun = (r == 0) ? rrun + 1 : 0;
    repeat (2) @(negedge core_clk);
    lf = lrun >= RL;
    rf = rrun >= RL;
    want = pins_exp(lf, rf, mrg, pol);
    check("pins", {p1, p2, oe}, want);
    check("decoded", {rsil, lsil}, mrg ? {lf & rf, 1'b0} : {rf, lf});
  endtask : step
  task automatic modstep(logic [SAMPLE_W-1:0] v);
    mi = v;
    ms = 1;
    @(negedge core_clk) ms = 0;
    @(negedge core_clk);
    hi = (code > hi) ? code : hi;
    lo = (code < lo) ? code : lo;
  endtask : modstep
  // ---------------------------------------------------------------
  // hang guard and main sequence
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (++cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hcba8a0b8));
    repeat (4) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    check("rst pins", {p1, p2, oe}, 3'b001);
    check("osr", osr, 8'h40);
    for (int k = 0; k < 4; k++) begin
      pol = k[0];
      mrg = k[1];
      ld = 1;
      @(negedge core_clk) ld = 0;
      repeat (14) begin
        step(($urandom_range(3) == 0) ? SAMPLE_W'($urandom) : '0,
          ($urandom_range(3) == 0) ? SAMPLE_W'($urandom) : '0);
      end
      // corner: both channels silent, then each channel wakes alone
      repeat (RL + 1) step('0, '0);
      step(SAMPLE_W'(1), '0);
      step('0, 24'h800000);
    end
    // rate pairs: double request and clock ratio around the 256 limit
    for (int k = 0; k < 4; k++) begin
      dbl = k != 0;
      ratio = (k == 2) ? 11'h0ff : (k == 3) ? 11'h480 : 11'h100;
      @(negedge core_clk);
      check("osr", osr, osr_exp(dbl, ratio));
    end
    repeat (40) modstep(24'h7fffff);
    // mid-run reset so the negative run starts from a clean loop
    rst = 1;
    @(negedge core_clk);
    check("mid rst", {p1, p2, oe, code, osr}, {6'b001100, 8'h40});
    rst = 0;
    repeat (3) modstep('0);
    check("zero code", code, CODE_MID);
    repeat (40) modstep(24'h800000);
    check("code hi", hi, CODE_MAX);
    check("code lo", lo, 3'h0);
    rst = 1;
    @(negedge core_clk);
    check("rst again", {p1, p2, oe, osr}, {3'b001, 8'h40});
    report_and_stop();
  end
endmodule : zfm_ctrl_tb
`default_nettype wire

// *** zfm_flag_monitor.sv ***
// far-side monitor that decodes the two flag pins into silence flags
// assumes the same polarity as loaded into the block; merged mode is read from flag_pin2_oe
`timescale 1ns/1ps
`default_nettype none
module zfm_flag_monitor (
  // flag pins and current setting
  input wire logic flag_pin1,
  input wire logic flag_pin2,
  input wire logic flag_pin2_oe,
  input wire logic pol,
  // decoded silence
  output logic right_silent,
  output logic left_silent
);
  logic pin2_wire;
  // board pull-down on pin two while nobody drives it
  assign pin2_wire = flag_pin2_oe ? flag_pin2 : 1'b0;
  assign right_silent = flag_pin1 ^ pol;
  assign left_silent = flag_pin2_oe ? (pin2_wire ^ pol) : 1'b0;
endmodule : zfm_flag_monitor
`default_nettype wire

// *** zfm_pkg.sv ***
// package for the zero flag and modulator control block
// assumes a single 100 MHz core clock domain
package zfm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // silence run length in samples before a flag rises
  localparam int ZERO_RUN_SAMPLES = 1024;
  localparam int SAMPLE_W = 24;
  localparam int MOD_LEVELS = 8;
  localparam int MOD_ORDER = 4;
  localparam int OSR_BASE = 64;
  localparam int OSR_DOUBLE = 128;
  localparam int SCK_RATIO_MIN = 256;
  localparam logic RST_POLARITY = 1'b0;
  localparam logic RST_MERGE = 1'b0;
  // error feedback keeps a few guard bits above the sample width
  localparam int ACC_W = SAMPLE_W + 8;
  localparam logic [2:0] CODE_MAX = 3'h7;
  // mid code, the output level for a zero input
  localparam logic [2:0] CODE_MID = 3'h4;
endpackage : zfm_pkg
